// [shared/cfc_map.svh]
// timing counts, field positions and reset values of the frame codec
// assumes a 25 ns system clock; included by the core module only
`ifndef CFC_MAP_SVH
`define CFC_MAP_SVH

// ---------------------------------------------------------------
// link timing
// ---------------------------------------------------------------
`define CFC_CLK_NS 25
`define CFC_ETU_NS 9440
`define CFC_ETU_CYC (`CFC_ETU_NS / `CFC_CLK_NS)
`define CFC_SUB_NS 1181
`define CFC_GUARD_NS (128 * `CFC_SUB_NS)
`define CFC_GUARD_CYC ((`CFC_GUARD_NS + `CFC_CLK_NS - 1) / `CFC_CLK_NS)
`define CFC_SOF_LO_ETU 10
`define CFC_SOF_HI_MIN_ETU 2
`define CFC_SOF_HI_MAX_ETU 3
`define CFC_GAP_ETU 16
`define CFC_SUB_HALF_EDGES 3

// ---------------------------------------------------------------
// crc and command set
// ---------------------------------------------------------------
`define CFC_CRC_PRESET 16'hffff
`define CFC_CRC_POLY 16'h8408
`define CFC_CRC_RESID 16'hf0b8
`define CFC_OP_READ 8'h08
`define CFC_OP_WRITE 8'h09
`define CFC_OP_UID 8'h0b
`define CFC_LEN_READ 5'd4
`define CFC_LEN_WRITE 5'd8
`define CFC_LEN_UID 5'd3

// ---------------------------------------------------------------
// block map and reset values
// ---------------------------------------------------------------
`define CFC_ADDR_SYS 8'hff
`define CFC_ADDR_CNT_A 8'h05
`define CFC_ADDR_CNT_B 8'h06
`define CFC_LOCK_LSB 16
`define CFC_USER_RST 32'hffffffff
`define CFC_CNT_A_RST 32'hfffffffe
`define CFC_CNT_B_RST 32'hffffffff
`define CFC_SYS_HI_RST 24'hffffff

`endif

// [shared/cfc_pkg.sv]
// state types of the contactless frame codec
// assumes nothing beyond a SystemVerilog compiler
package cfc_pkg;

   // receive framer states
   typedef enum logic [5:0] {
      RX_IDLE = 6'b000001,
      RX_SOFL = 6'b000010,
      RX_SOFH = 6'b000100,
      RX_WAIT = 6'b001000,
      RX_BIT = 6'b010000,
      RX_EOFH = 6'b100000
   } cfc_rx_e;

   // answer framer states
   typedef enum logic [5:0] {
      TX_IDLE = 6'b000001,
      TX_GUARD = 6'b000010,
      TX_SYNC = 6'b000100,
      TX_SOF = 6'b001000,
      TX_CHAR = 6'b010000,
      TX_EOF = 6'b100000
   } cfc_tx_e;

   // command executor states
   typedef enum logic [2:0] {
      EX_IDLE = 3'b001,
      EX_POP = 3'b010,
      EX_ACT = 3'b100
   } cfc_ex_e;

endpackage

// [rtl/cfc_fifo.sv]
// small synchronous fifo with valid/ready on both sides and a flush
// assumes one clock, a clock enable and an asynchronous high reset
`timescale 1ns/1ps
module cfc_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_flush,
   // fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [W-1:0] i_data,
   // drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [W-1:0] o_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0] wp;
   logic [AW:0] rp;

   // full when pointers differ only in the wrap bit
   wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   wire empty = (wp == rp);
   wire do_wr = i_valid && !full;
   wire do_rd = i_ready && !empty;
   assign o_ready = !full;
   assign o_valid = !empty;
   assign o_data = mem[rp[AW-1:0]];

   // pointers; flush wins over traffic so a bad frame leaves nothing
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         wp <= '0;
         rp <= '0;
      end else if (i_ce) begin
         if (i_flush) begin
            wp <= '0;
            rp <= '0;
         end else begin
            if (do_wr) wp <= wp + 1'b1;
            if (do_rd) rp <= rp + 1'b1;
         end
      end
   end

   // storage needs no reset
   always_ff @(posedge i_clk_sys) begin
      if (i_ce && do_wr && !i_flush) mem[wp[AW-1:0]] <= i_data;
   end
endmodule

// [rtl/cfc_core.sv]
// frame codec and block map of a passive contactless memory tag
// assumes a demodulated request envelope and a field-derived clock
// Notes on behaviour
// - every byte travels as a ten-bit character, lsb first.
// - one bit period is 9.44 us; all frame timing counts it.
// - start bit zero, eight data bits lsb first, stop bit one.
// - any receive error means no execution and no error frame.
// - request sof is 10 periods low, then 2 to 3 periods high.
// - request eof is 10 periods low then one rising edge.
// - answers use bpsk subcarrier load modulation, same characters.
// - answer sof is 10 periods zero then 2 periods one.
// - answer eof after crc is 10 periods zero then 2 one.
// - modulation stays off for 128 subcarrier periods between frames.
// - then 128 periods of reference phase; next transition starts the sof.
// - 16-bit type b crc preset to all ones per frame.
// - two crc bytes before eof cover every byte after sof.
// - request with bad crc is discarded without answer.
// - crc goes low byte first, each byte lsb first.
// - sixteen 32-bit user blocks, all readable.
// - a permitted block write replaces all 32 bits at once.
// - blocks 0-4, 7-15 eeprom, 5-6 counters, 255 system, rom id.
// - counter write only accepted when new value is lower.
// - system bit 16+n at zero write-protects block n.
// - system block write only clears bits, never sets.
`timescale 1ns/1ps
`include "cfc_map.svh"
module cfc_core import cfc_pkg::*; #(
   parameter int P_GUARD_CYC = `CFC_GUARD_CYC,
   parameter int P_SYNC_CYC = `CFC_GUARD_CYC,
   parameter logic [63:0] P_UID = 64'h0123_4567_89ab_cdef, // arbitrary
   parameter logic [7:0] P_FIXED_ID = 8'h5a // arbitrary
) (
   // clock, reset, enable
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   // link side
   input wire logic i_link_clk,
   input wire logic i_rx_env,
   output logic o_mod,
   output logic o_tx_active
);
   localparam logic [12:0] ETU_M1 = 13'(`CFC_ETU_CYC - 1);
   localparam logic [12:0] HALF_M1 = 13'(`CFC_ETU_CYC / 2 - 1);
   localparam logic [12:0] LO_MIN = 13'(`CFC_ETU_CYC * (2 * `CFC_SOF_LO_ETU - 1) / 2);
   localparam logic [12:0] LO_MAX = 13'(`CFC_ETU_CYC * (2 * `CFC_SOF_LO_ETU + 1) / 2);
   localparam logic [12:0] HI_MIN = 13'(`CFC_ETU_CYC * (2 * `CFC_SOF_HI_MIN_ETU - 1) / 2);
   localparam logic [12:0] HI_MAX = 13'(`CFC_ETU_CYC * (2 * `CFC_SOF_HI_MAX_ETU + 1) / 2);
   localparam logic [12:0] GAP = 13'(`CFC_ETU_CYC * `CFC_GAP_ETU);
   localparam logic [12:0] GUARD_M1 = 13'(P_GUARD_CYC - 1);
   localparam logic [12:0] SYNC_M1 = 13'(P_SYNC_CYC - 1);
   localparam logic [1:0] SUB_M1 = 2'(`CFC_SUB_HALF_EDGES - 1);

   // reflected type b crc step over one byte
   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `CFC_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers and link clock edges
   // ---------------------------------------------------------------
   logic rx_s1, rx_s2, rx_s3, lk_s1, lk_s2, lk_s3;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         {rx_s1, rx_s2, rx_s3} <= 3'b111;
         {lk_s1, lk_s2, lk_s3} <= 3'b000;
      end else if (i_ce) begin
         {rx_s3, rx_s2, rx_s1} <= {rx_s2, rx_s1, i_rx_env};
         {lk_s3, lk_s2, lk_s1} <= {lk_s2, lk_s1, i_link_clk};
      end
   end
   wire rx_fall = rx_s3 && !rx_s2;
   wire rx_rise = !rx_s3 && rx_s2;
   wire lk_rise = !lk_s3 && lk_s2;

   // subcarrier from the field clock; its phase carries bpsk data
   logic sub;
   logic [1:0] sub_cnt;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sub <= 1'b0;
         sub_cnt <= 2'h0;
      end else if (i_ce && lk_rise) begin
         sub_cnt <= (sub_cnt == SUB_M1) ? 2'h0 : sub_cnt + 2'h1;
         if (sub_cnt == SUB_M1) sub <= !sub;
      end
   end

   // ---------------------------------------------------------------
   // request framer
   // ---------------------------------------------------------------
   cfc_rx_e rx_st;
   cfc_tx_e tx_st;
   cfc_ex_e ex_st;
   logic [12:0] rx_cnt;
   logic [3:0] rx_bitn;
   logic [9:0] rx_sh;
   logic [15:0] rx_crc;
   logic [4:0] rx_n;
   logic fr_ok, fr_bad, push, fifo_rdy;
   wire [9:0] ch = {rx_s2, rx_sh[9:1]};
   wire rx_smp = (rx_cnt == ((rx_bitn == 4'h0) ? HALF_M1 : ETU_M1));
   wire ch_ok = !ch[0] && ch[9];
   wire rx_go = rx_fall && (tx_st == TX_IDLE) && (ex_st == EX_IDLE);

   // the tag is half duplex: requests are ignored while it answers
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         rx_st <= RX_IDLE;
         rx_cnt <= 13'h0;
         rx_bitn <= 4'h0;
         rx_sh <= 10'h3ff;
         rx_crc <= `CFC_CRC_PRESET;
         rx_n <= 5'h0;
         {fr_ok, fr_bad, push} <= 3'b000;
      end else if (i_ce) begin
         {fr_ok, fr_bad, push} <= 3'b000;
         rx_cnt <= rx_cnt + 13'h1;
         case (rx_st)
            RX_IDLE: if (rx_go) begin
               rx_st <= RX_SOFL;
               rx_cnt <= 13'h0;
               rx_crc <= `CFC_CRC_PRESET;
               rx_n <= 5'h0;
            end
            RX_SOFL: if (rx_rise) begin
               rx_cnt <= 13'h0;
               rx_st <= (rx_cnt >= LO_MIN) ? RX_SOFH : RX_IDLE;
            end else if (rx_cnt > LO_MAX) begin
               rx_st <= RX_IDLE;
            end
            RX_SOFH: if (rx_fall) begin
               rx_cnt <= 13'h0;
               rx_bitn <= 4'h0;
               rx_st <= (rx_cnt >= HI_MIN) ? RX_BIT : RX_IDLE;
            end else if (rx_cnt > HI_MAX) begin
               rx_st <= RX_IDLE;
            end
            RX_WAIT: if (rx_fall) begin
               rx_cnt <= 13'h0;
               rx_bitn <= 4'h0;
               rx_st <= RX_BIT;
            end else if (rx_cnt > GAP) begin
               rx_st <= RX_IDLE;
               fr_bad <= 1'b1;
            end
            RX_BIT: if (rx_smp) begin
               rx_cnt <= 13'h0;
               rx_sh <= ch;
               rx_bitn <= rx_bitn + 4'h1;
               if (rx_bitn == 4'h9) begin
                  if (ch == 10'h0) begin
                     rx_st <= RX_EOFH;
                  end else if (ch_ok && fifo_rdy) begin
                     push <= 1'b1;
                     rx_crc <= crc_upd(rx_crc, ch[8:1]);
                     rx_n <= rx_n + 5'h1;
                     rx_st <= RX_WAIT;
                  end else begin
                     fr_bad <= 1'b1;
                     rx_st <= RX_IDLE;
                  end
               end
            end
            RX_EOFH: if (rx_rise) begin
               rx_st <= RX_IDLE;
               fr_ok <= (rx_crc == `CFC_CRC_RESID);
               fr_bad <= (rx_crc != `CFC_CRC_RESID);
            end else if (rx_cnt > ETU_M1) begin
               rx_st <= RX_IDLE;
               fr_bad <= 1'b1;
            end
            default: rx_st <= RX_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // request byte buffer; a full buffer fails the frame
   // ---------------------------------------------------------------
   logic fq_valid;
   logic [7:0] fq_data;
   wire pop = (ex_st == EX_POP);
   cfc_fifo #(.W(8), .D(16)) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_flush(fr_bad),
      .i_valid(push),
      .o_ready(fifo_rdy),
      .i_data(rx_sh[8:1]),
      .o_valid(fq_valid),
      .i_ready(pop),
      .o_data(fq_data)
   );

   // ---------------------------------------------------------------
   // command executor and block map
   // ---------------------------------------------------------------
   logic [31:0] mem [16];
   logic [31:0] sys;
   logic [7:0] cmd, addr;
   logic [31:0] wdat;
   logic [3:0] k;
   wire [3:0] ba = addr[3:0];
   wire is_user = (addr < 8'h10);
   wire is_cnt = (addr == `CFC_ADDR_CNT_A) || (addr == `CFC_ADDR_CNT_B);
   wire unlocked = sys[`CFC_LOCK_LSB + ba];
   wire wr_len = (cmd == `CFC_OP_WRITE) && (rx_n == `CFC_LEN_WRITE);
   wire wr_go = wr_len && is_user && unlocked && (!is_cnt || wdat < mem[ba]);
   wire sys_go = wr_len && (addr == `CFC_ADDR_SYS);
   wire rd_go = (cmd == `CFC_OP_READ) && (rx_n == `CFC_LEN_READ)
      && (is_user || addr == `CFC_ADDR_SYS);
   wire uid_go = (cmd == `CFC_OP_UID) && (rx_n == `CFC_LEN_UID);
   wire [31:0] rd_word = (addr == `CFC_ADDR_SYS) ? sys : mem[ba];
   wire act = (ex_st == EX_ACT);

   // bytes are popped only after the crc passed, so bad frames never act
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ex_st <= EX_IDLE;
         k <= 4'h0;
         {cmd, addr} <= 16'h0;
         wdat <= 32'h0;
      end else if (i_ce) begin
         case (ex_st)
            EX_IDLE: if (fr_ok) begin
               ex_st <= EX_POP;
               k <= 4'h0;
            end
            EX_POP: if (fq_valid) begin
               k <= k + 4'h1;
               if (k == 4'h0) cmd <= fq_data;
               if (k == 4'h1) addr <= fq_data;
               if (k >= 4'h2 && k <= 4'h5) wdat[{k[1:0] - 2'h2, 3'b000} +: 8] <= fq_data;
            end else begin
               ex_st <= EX_ACT;
            end
            default: ex_st <= EX_IDLE;
         endcase
      end
   end

   // whole-word updates; the system block only ever loses ones
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < 16; i++) mem[i] <= `CFC_USER_RST;
         mem[5] <= `CFC_CNT_A_RST;
         mem[6] <= `CFC_CNT_B_RST;
         sys <= {`CFC_SYS_HI_RST, P_FIXED_ID};
      end else if (i_ce && act) begin
         if (wr_go) mem[ba] <= wdat;
         if (sys_go) sys <= sys & wdat;
      end
   end

   // ---------------------------------------------------------------
   // answer framer
   // ---------------------------------------------------------------
   logic [12:0] tx_cnt;
   logic [3:0] tx_bitn, tb, len;
   logic [63:0] ans;
   logic [7:0] tx_byte;
   logic [15:0] tx_crc;
   wire tick = (tx_cnt == ETU_M1);
   wire [3:0] nx = tb + 4'h1;
   wire [7:0] nx_byte = (nx < len) ? ans[{nx[2:0], 3'b000} +: 8] :
      (nx == len) ? ~tx_crc[7:0] : ~tx_crc[15:8];
   wire [9:0] chr = {1'b1, tx_byte, 1'b0};
   wire tx_bit = (tx_st == TX_CHAR) ? chr[tx_bitn] :
      (tx_st == TX_SOF || tx_st == TX_EOF) ? (tx_bitn >= 4'ha) : 1'b1;
   wire tx_on = (tx_st == TX_SYNC) || (tx_st == TX_SOF) || (tx_st == TX_CHAR)
      || (tx_st == TX_EOF);
   wire next_mod = tx_on && (sub ^ !tx_bit);

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         tx_st <= TX_IDLE;
         {tx_cnt, tx_bitn, tb, len} <= '0;
         ans <= 64'h0;
         tx_byte <= 8'h0;
         tx_crc <= `CFC_CRC_PRESET;
      end else if (i_ce) begin
         tx_cnt <= tx_cnt + 13'h1;
         case (tx_st)
            TX_IDLE: if (act && (rd_go || uid_go)) begin
               tx_st <= TX_GUARD;
               tx_cnt <= 13'h0;
               ans <= uid_go ? P_UID : {32'h0, rd_word};
               len <= uid_go ? 4'h8 : 4'h4;
            end
            TX_GUARD: if (tx_cnt == GUARD_M1) begin
               tx_st <= TX_SYNC;
               tx_cnt <= 13'h0;
            end
            TX_SYNC: if (tx_cnt == SYNC_M1) begin
               tx_st <= TX_SOF;
               {tx_cnt, tx_bitn} <= '0;
            end
            TX_SOF: if (tick) begin
               tx_cnt <= 13'h0;
               tx_bitn <= tx_bitn + 4'h1;
               if (tx_bitn == 4'hb) begin
                  tx_st <= TX_CHAR;
                  {tx_bitn, tb} <= '0;
                  tx_byte <= ans[7:0];
                  tx_crc <= crc_upd(`CFC_CRC_PRESET, ans[7:0]);
               end
            end
            TX_CHAR: if (tick) begin
               tx_cnt <= 13'h0;
               tx_bitn <= tx_bitn + 4'h1;
               if (tx_bitn == 4'h9) begin
                  tx_bitn <= 4'h0;
                  tb <= nx;
                  tx_byte <= nx_byte;
                  if (nx < len) tx_crc <= crc_upd(tx_crc, nx_byte);
                  if (tb == len + 4'h1) tx_st <= TX_EOF;
               end
            end
            TX_EOF: if (tick) begin
               tx_cnt <= 13'h0;
               tx_bitn <= tx_bitn + 4'h1;
               if (tx_bitn == 4'hb) tx_st <= TX_IDLE;
            end
            default: tx_st <= TX_IDLE;
         endcase
      end
   end

   // registered load modulation drive
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_mod <= 1'b0;
         o_tx_active <= 1'b0;
      end else if (i_ce) begin
         o_mod <= next_mod;
         o_tx_active <= (tx_st != TX_IDLE);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   a_guard_quiet: assert property (tx_st == TX_GUARD |=> !o_mod)
      else $error("modulation during turnaround guard");
   a_sof_zero_bits: assert property (tx_st == TX_SOF && tx_bitn < 4'ha |-> !tx_bit)
      else $error("answer sof bit not zero");
   a_eof_tail_ones: assert property (tx_st == TX_EOF && tx_bitn >= 4'ha |-> tx_bit)
      else $error("answer eof tail not one");
   a_char_framing: assert property (tx_st == TX_CHAR |-> (tx_bitn != 4'h0 || !tx_bit)
      && (tx_bitn != 4'h9 || tx_bit))
      else $error("answer character framing wrong");
   a_sync_phase: assert property (i_ce && tx_st == TX_SYNC |=> o_mod == $past(sub))
      else $error("sync phase not reference");
   a_counter_down: assert property (mem[5] != $past(mem[5]) |-> mem[5] < $past(mem[5]))
      else $error("counter increased");
   a_sys_no_set: assert property ((sys & ~$past(sys)) == 32'h0)
      else $error("system block bit set");
   a_locked_hold: assert property (act && is_user && !unlocked |=> $stable(mem[ba]))
      else $error("locked block changed");
   a_bad_no_answer: assert property (fr_bad |=> ex_st == EX_IDLE ##1 tx_st == TX_IDLE)
      else $error("bad frame started an action");
   a_guard_length: assert property (i_ce && tx_st == TX_IDLE ##1 tx_st == TX_GUARD
      |-> !o_mod [*8])
      else $error("guard too short");

   c_read_answer: cover property (act && rd_go);
   c_write_done: cover property (act && wr_go);
   c_crc_reject: cover property (rx_st == RX_EOFH && rx_rise && fr_bad == 1'b0
      ##1 fr_bad);
   c_uid_answer: cover property (act && uid_go);
endmodule

// [verification/cfc_reader_model.sv]
// reader-side model: field clock, request envelope and bpsk answer decoding
// assumes the tag's 25 ns system clock as the model's timebase
`timescale 1ns/1ps
module cfc_reader_model (
   // timebase and tag outputs
   input wire logic i_clk_sys,
   input wire logic i_mod,
   input wire logic i_tx_active,
   // link lines
   output logic o_link_clk,
   output logic o_rx_env
);
   localparam int BIT_PERIOD_UNIT = 377;
   logic [5:0] ref_ring;
   logic [7:0] n_edge;
   logic lvl;

   // ---------------------------------------------------------------
   // field clock and answer decoder
   // ---------------------------------------------------------------
   // the carrier powers the tag, so its clock runs free between frames
   initial begin
      o_link_clk = 1'b0;
      o_rx_env = 1'b1;
      #7;
      forever #100 o_link_clk = ~o_link_clk;
   end

   // reference phase learnt in the sync burst, then replayed every 6 edges
   always @(posedge o_link_clk) begin
      n_edge <= !i_tx_active ? 8'h00 :
         ((i_mod || n_edge != 8'h00) && n_edge < 8'd12) ? n_edge + 8'd1 : n_edge;
      ref_ring <= {ref_ring[4:0], (n_edge == 8'd12) ? ref_ring[5] : i_mod};
      lvl <= (n_edge == 8'd12) ? ~(i_mod ^ ref_ring[5]) : 1'b1;
   end

   // ---------------------------------------------------------------
   // request side
   // ---------------------------------------------------------------
   task automatic hold(input logic v, input int etus);
      o_rx_env <= v;
      repeat (etus * BIT_PERIOD_UNIT) @(posedge i_clk_sys);
   endtask

   task automatic send_frame(input logic [7:0] fr [0:9], input int n);
      int i;
      int k;
      @(posedge i_clk_sys);
      hold(1'b0, 10);
      hold(1'b1, 2);
      for (i = 0; i < n; i++) begin
         hold(1'b0, 1);
         for (k = 0; k < 8; k++) hold(fr[i][k], 1);
         hold(1'b1, 1);
      end
      hold(1'b0, 10);
      // a lone rising edge ends the frame; the tag's turnaround starts from it
      hold(1'b1, 0);
   endtask

   // ---------------------------------------------------------------
   // answer side
   // ---------------------------------------------------------------
   // bounded so a silent tag cannot hang the model
   task automatic wait_lvl(input logic v);
      int n;
      n = 0;
      while (lvl !== v && n < 40000) begin
         @(posedge i_clk_sys);
         n++;
      end
   endtask

   // delimiter: ten units low, then high
   task automatic delim(inout logic ok);
      wait_lvl(1'b0);
      repeat (BIT_PERIOD_UNIT * 19 / 2) @(posedge i_clk_sys);
      ok &= (lvl === 1'b0);
      repeat (BIT_PERIOD_UNIT) @(posedge i_clk_sys);
      ok &= (lvl === 1'b1);
   endtask

   // mid-bit sampling from each start edge; crc is judged by the bench
   task automatic get_answer(output logic [47:0] q, output logic ok);
      int i;
      int k;
      ok = 1'b1;
      q = 48'h0;
      delim(ok);
      repeat (BIT_PERIOD_UNIT) @(posedge i_clk_sys);
      ok &= (lvl === 1'b1);
      for (i = 0; i < 6; i++) begin
         wait_lvl(1'b0);
         repeat (BIT_PERIOD_UNIT / 2) @(posedge i_clk_sys);
         ok &= (lvl === 1'b0);
         for (k = 0; k < 8; k++) begin
            repeat (BIT_PERIOD_UNIT) @(posedge i_clk_sys);
            q[8*i+k] = lvl;
         end
         repeat (BIT_PERIOD_UNIT) @(posedge i_clk_sys);
         ok &= (lvl === 1'b1);
      end
      delim(ok);
   endtask
endmodule

// [verification/contactless_frame_codec_memmap_tb.sv]
// bench for the frame codec: a dropped bad-crc write, then a block read
// assumes the reader model beside the core and shortened guard/sync counts
`timescale 1ns/1ps
module contactless_frame_codec_memmap_tb;
   localparam int G = 40;
   localparam int S = 240;
   logic i_clk_sys;
   logic i_rst;
   logic link_clk;
   logic rx_env;
   logic mod;
   logic tx_active;
   logic [7:0] fr [0:9];
   logic [47:0] ans;
   logic ok;
   logic [15:0] c;
   int n;
   int fails;
   int samples_checked;

   cfc_core #(.P_GUARD_CYC(G), .P_SYNC_CYC(S)) dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_ce(1'b1), .i_link_clk(link_clk), .i_rx_env(rx_env), .o_mod(mod),
      .o_tx_active(tx_active));
   cfc_reader_model rdr_u (.i_clk_sys(i_clk_sys), .i_mod(mod), .i_tx_active(tx_active),
      .o_link_clk(link_clk), .o_rx_env(rx_env));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] crc16(input logic [7:0] d [0:9], input int len);
      logic [15:0] r;
      int i;
      int k;
      r = 16'hffff;
      for (i = 0; i < len; i++) begin
         r = r ^ {8'h00, d[i]};
         for (k = 0; k < 8; k++) r = r[0] ? ((r >> 1) ^ 16'h8408) : (r >> 1);
      end
      return ~r;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog, tests
   // ---------------------------------------------------------------
   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end

   // two frames plus one answer need about 95k cycles
   initial begin
      repeat (99000) @(posedge i_clk_sys);
      fails++;
      wrap_up;
   end

   initial begin
      i_rst = 1'b1;
      fails = 0;
      samples_checked = 0;
      repeat (10) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      // lower counter value, but the crc is corrupted
      fr = '{8'h09, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      c = crc16(fr, 6) ^ 16'h0001;
      fr[6] = c[7:0];
      fr[7] = c[15:8];
      rdr_u.send_frame(fr, 8);
      // outputs are looked at on the falling edge, where they are settled
      repeat (G + 200) @(negedge i_clk_sys);
      chk({31'h0, tx_active}, 32'h0);
      // read counter 5 back
      fr[0] = 8'h08;
      c = crc16(fr, 2);
      fr[2] = c[7:0];
      fr[3] = c[15:8];
      rdr_u.send_frame(fr, 4);
      n = 0;
      while (tx_active !== 1'b1 && n < 2000) begin
         @(negedge i_clk_sys);
         n++;
      end
      n = 0;
      while (mod !== 1'b1 && n < 2000) begin
         @(negedge i_clk_sys);
         n++;
      end
      chk(32'(n >= G - 2 && n <= G + 40), 32'h1);
      n = 0;
      while (rdr_u.lvl !== 1'b0 && n < 2000) begin
         @(posedge i_clk_sys);
         n++;
      end
      chk(32'(n >= S - 30 && n <= S + 15), 32'h1);
      rdr_u.get_answer(ans, ok);
      chk({31'h0, ok}, 32'h1);
      chk(ans[31:0], 32'hfffffffe);
      fr = '{8'hfe, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      c = crc16(fr, 4);
      chk({16'h0, ans[47:32]}, {16'h0, c});
      n = 0;
      while (tx_active !== 1'b0 && n < 1000) begin
         @(negedge i_clk_sys);
         n++;
      end
      chk({31'h0, tx_active}, 32'h0);
      // reader pause before any further request
      repeat (200) @(posedge i_clk_sys);
      wrap_up;
   end
endmodule
